// file: tb/fra_fetch_model.sv
// Purpose: Fetch and decode stage model that offers instruction words.
// Assumes: instr_ready is high one cycle in each instruction cycle.
// Notes: Between words the word lines carry the inverse of the last word.
`timescale 1ns/1ps
module fra_fetch_model
  import fra_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic instr_ready, // Executor takes a word.
  output logic instr_valid, // Word offered.
  output logic [INSTR_W-1:0] instr_word // Offered word.
);
  // ==========================================================
  // Offer one word
  // ==========================================================
  initial begin
    instr_valid = 1'b0;
    instr_word = '0;
  end
  // The word is held until the edge where ready is seen high, so a slow
  // instruction cycle never loses or repeats a word.
  task automatic send(input logic [INSTR_W-1:0] w);
    while (rstn !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(negedge clk_sys); while (instr_ready !== 1'b1);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    instr_word <= ~w;
    @(negedge clk_sys);
  endtask : send
endmodule : fra_fetch_model

// file: tb/tb_file_register_alu_ops.sv
// Purpose: Self-checking bench for the accumulator and file register executor.
// Assumes: Default instruction cycle length; registers seen over the software port.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
module tb_file_register_alu_ops;
  import fra_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid;
  logic [INSTR_W-1:0] instr_word;
  logic instr_ready;
  logic skip_pulse;
  logic [7:0] acc_out;
  logic zero_flag;
  logic [SW_ADDR_W-1:0] sw_addr = 8'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic [7:0] rv;
  int fail_count = 0;
  int cmp_count = 0;
  int skip_cnt = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  fra_exec dut_u (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .skip_pulse(skip_pulse), .acc_out(acc_out), .zero_flag(zero_flag),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  fra_fetch_model fetch_u (.clk_sys(clk_sys), .rstn(rstn), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word));
  // ==========================================================
  // Helpers
  // ==========================================================
  always @(posedge clk_sys) begin
    if (skip_pulse === 1'b1) begin
      skip_cnt++;
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    @(negedge clk_sys);
    d = sw_rdata;
  endtask : rd
  task automatic ex(input logic [INSTR_W-1:0] w);
    fetch_u.send(w);
  endtask : ex
  function automatic logic [13:0] fop(input logic [5:0] opc, input logic d, input logic [6:0] f);
    return {opc, d, f};
  endfunction : fop
  function automatic logic [13:0] ldl(input logic [7:0] k);
    return {OPC_LOAD_LIT, 2'b00, k};
  endfunction : ldl
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk("acc reset", acc_out, ACC_RST);
    rd(8'h05, rv); chk("freg reset", rv, FREG_RST);
    @(negedge clk_sys); chk("rdata idle", sw_rdata, 8'h00);
    wr(8'h81, 8'hFF); rd(8'h81, rv); chk("status ro", rv, 8'h00);
    rd(8'h82, rv); chk("unmapped", rv, 8'h00);
    ex(ldl(8'hA5)); chk("load acc", acc_out, 8'hA5);
    ex({OPC_STORE_ACC, 7'h7F}); rd(8'h7F, rv); chk("store 127", rv, 8'hA5);
    chk("store zero", {7'h00, zero_flag}, 8'h00);
    ex(ldl(8'h00)); ex({OPC_OR_LIT, 8'h00}); chk("orl zero", {7'h00, zero_flag}, 8'h01);
    ex(ldl(8'h00)); chk("load keeps z", {7'h00, zero_flag}, 8'h01);
    ex({OPC_OR_LIT, 8'h81}); chk("orl acc", acc_out, 8'h81);
    chk("orl nz", {7'h00, zero_flag}, 8'h00);
    wr(8'h10, 8'h00); ex(ldl(8'h00)); ex(fop(OPC_OR_FREG, 1'b1, 7'h10));
    chk("orf z d1", {7'h00, zero_flag}, 8'h01);
    wr(8'h11, 8'h0C); ex(ldl(8'h30)); ex(fop(OPC_OR_FREG, 1'b0, 7'h11));
    chk("orf acc", acc_out, 8'h3C);
    rd(8'h11, rv); chk("orf d0 freg", rv, 8'h0C);
    ex(fop(OPC_OR_FREG, 1'b1, 7'h11)); rd(8'h11, rv); chk("orf d1 freg", rv, 8'h3C);
    wr(8'h05, 8'h01); ex(fop(OPC_DEC_SKIP, 1'b1, 7'h05)); rd(8'h81, rv); chk("skip armed", rv, 8'h02);
    ex(ldl(8'h33));
    chk("dec squash", acc_out, 8'h3C);
    rd(8'h05, rv); chk("dec d1", rv, 8'h00);
    chk("dec skips", skip_cnt[7:0], 8'h01);
    wr(8'h06, 8'h03); ex(fop(OPC_DEC_SKIP, 1'b0, 7'h06)); chk("dec d0", acc_out, 8'h02);
    rd(8'h06, rv); chk("dec d0 freg", rv, 8'h03);
    ex(ldl(8'h44)); chk("dec no skip", acc_out, 8'h44);
    wr(8'h07, 8'hFF); ex(fop(OPC_INC_SKIP, 1'b0, 7'h07)); chk("inc d0", acc_out, 8'h00);
    chk("inc keeps z", {7'h00, zero_flag}, 8'h00);
    ex(ldl(8'h55)); chk("inc squash", acc_out, 8'h00);
    rd(8'h07, rv); chk("inc d0 freg", rv, 8'hFF);
    wr(8'h00, 8'h7E); ex(fop(OPC_INC_SKIP, 1'b1, 7'h00)); rd(8'h00, rv); chk("inc d1", rv, 8'h7F);
    ex(ldl(8'h66)); chk("inc no skip", acc_out, 8'h66);
    ex(14'h3FFF); chk("unknown op", acc_out, 8'h66);
    ex({OPC_LOAD_LIT, 2'b11, 8'h12}); chk("load spare", acc_out, 8'h12);
    repeat (4) @(posedge clk_sys);
    chk("skip count", skip_cnt[7:0], 8'h02);
    report_and_stop();
  end
endmodule : tb_file_register_alu_ops

// file: verilog/fra_alu.sv
// Purpose: Result arithmetic for the six executed instructions.
// Assumes: Operands are stable within the cycle.
// Notes: Purely combinational.
`timescale 1ns/1ps
module fra_alu
  import fra_pkg::*;
(
  fra_alu_if.alu bus // Operands in, result out.
);
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic [7:0] or_lit_val;
  logic [7:0] or_freg_val;
  assign dec_val = bus.fval - 8'h01;
  assign inc_val = bus.fval + 8'h01;
  assign or_lit_val = bus.acc | bus.lit;
  assign or_freg_val = bus.acc | bus.fval;
  assign bus.result = (bus.op == FRA_OP_DEC_SKIP) ? dec_val :
                      (bus.op == FRA_OP_INC_SKIP) ? inc_val :
                      (bus.op == FRA_OP_OR_LIT) ? or_lit_val :
                      (bus.op == FRA_OP_OR_FREG) ? or_freg_val :
                      (bus.op == FRA_OP_LOAD_LIT) ? bus.lit :
                      (bus.op == FRA_OP_STORE_ACC) ? bus.acc : 8'h00;
  assign bus.zero = (bus.result == 8'h00);
endmodule : fra_alu

// file: verilog/fra_alu_if.sv
// Purpose: Carries operands and result between the executor and its ALU.
// Assumes: Purely combinational path, one clock domain.
// Notes: None.
`timescale 1ns/1ps
interface fra_alu_if;
  import fra_pkg::*;
  fra_op_t op;
  logic [7:0] acc;
  logic [7:0] fval;
  logic [7:0] lit;
  logic [7:0] result;
  logic zero;
  modport exec (output op, output acc, output fval, output lit, input result, input zero);
  modport alu (input op, input acc, input fval, input lit, output result, output zero);
endinterface : fra_alu_if

// file: verilog/fra_exec.sv
// Purpose: Executes six accumulator and file register instructions.
// Assumes: Decode stage offers words on instr_valid, taken when instr_ready.
// Notes: File registers live here; software reaches them over a plain port.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module fra_exec
  import fra_pkg::*;
#(
  parameter int CYC_LEN = CYC_CLKS
) (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic instr_valid, // Decode stage offers a word.
  input wire logic [INSTR_W-1:0] instr_word, // Instruction word.
  output logic instr_ready, // Word taken this cycle when valid.
  output logic skip_pulse, // One cycle: a word was squashed to a no-operation.
  output logic [7:0] acc_out, // Accumulator.
  output logic zero_flag, // Zero flag.
  input wire logic [SW_ADDR_W-1:0] sw_addr, // Software address.
  input wire logic [7:0] sw_wdata, // Software write data.
  input wire logic sw_wr, // Software write strobe.
  input wire logic sw_rd, // Software read strobe.
  output logic [7:0] sw_rdata // Read data, one cycle after the strobe.
);
  // ==========================================================
  // Instruction cycle divider
  // ==========================================================
  logic [$clog2(CYC_LEN+1)-1:0] cyc_cnt_q;
  logic cyc_en;
  assign cyc_en = (cyc_cnt_q == ($clog2(CYC_LEN+1))'(CYC_LEN - 1));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cyc_cnt_q <= '0;
    end else if (cyc_en) begin
      cyc_cnt_q <= '0;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + 1'b1;
    end
  end
  // Ready is the divider's enable itself, so a word is taken in the cycle the decode
  // stage sees ready; registering it would cost a clock on every instruction.
  assign instr_ready = cyc_en;

  // ==========================================================
  // Decode
  // ==========================================================
  logic take;
  logic skip_q;
  logic exec_en;
  fra_op_t op;
  logic dest_freg;
  logic [FADDR_W-1:0] faddr;
  assign take = instr_valid & cyc_en;
  assign exec_en = take & ~skip_q;
  assign faddr = instr_word[FADDR_W-1:0];
  assign dest_freg = instr_word[DEST_BIT];
  logic hit_dec;
  logic hit_inc;
  logic hit_orf;
  logic hit_orl;
  logic hit_ldl;
  logic hit_sto;
  assign hit_dec = (instr_word[13:8] == OPC_DEC_SKIP);
  assign hit_inc = (instr_word[13:8] == OPC_INC_SKIP);
  assign hit_orf = (instr_word[13:8] == OPC_OR_FREG);
  assign hit_orl = (instr_word[13:8] == OPC_OR_LIT);
  assign hit_ldl = (instr_word[13:10] == OPC_LOAD_LIT);
  assign hit_sto = (instr_word[13:7] == OPC_STORE_ACC);
  // Any other word decodes to a no-operation, so an unknown word changes nothing.
  assign op = hit_dec ? FRA_OP_DEC_SKIP :
              hit_inc ? FRA_OP_INC_SKIP :
              hit_orf ? FRA_OP_OR_FREG :
              hit_orl ? FRA_OP_OR_LIT :
              hit_ldl ? FRA_OP_LOAD_LIT :
              hit_sto ? FRA_OP_STORE_ACC : FRA_OP_NONE;

  // ==========================================================
  // File registers and ALU
  // ==========================================================
  logic [7:0] freg_q [2**FADDR_W];
  logic [7:0] acc_q;
  logic zero_q;
  fra_alu_if alu_bus ();
  fra_alu u_alu (
    .bus(alu_bus)
  );
  assign alu_bus.op = op;
  assign alu_bus.acc = acc_q;
  assign alu_bus.fval = freg_q[faddr];
  assign alu_bus.lit = instr_word[7:0];

  logic op_dec;
  logic op_inc;
  logic op_orf;
  logic op_orl;
  logic op_ldl;
  logic op_sto;
  logic has_dest;
  logic wr_acc;
  logic wr_freg;
  logic upd_zero;
  logic is_skip_op;
  assign op_dec = (op == FRA_OP_DEC_SKIP);
  assign op_inc = (op == FRA_OP_INC_SKIP);
  assign op_orf = (op == FRA_OP_OR_FREG);
  assign op_orl = (op == FRA_OP_OR_LIT);
  assign op_ldl = (op == FRA_OP_LOAD_LIT);
  assign op_sto = (op == FRA_OP_STORE_ACC);
  assign has_dest = op_dec | op_inc | op_orf;
  assign wr_acc = exec_en & ((has_dest & ~dest_freg) | op_orl | op_ldl);
  assign wr_freg = exec_en & ((has_dest & dest_freg) | op_sto);
  assign upd_zero = exec_en & (op_orl | op_orf);
  assign is_skip_op = op_dec | op_inc;

  // ==========================================================
  // Software port decode
  // ==========================================================
  logic sw_freg_sel;
  logic sw_acc_wr;
  logic [7:0] sw_rd_mux;
  assign sw_freg_sel = ~sw_addr[SW_ADDR_W-1];
  assign sw_acc_wr = sw_wr & (sw_addr == SW_ACC_OFS);
  assign sw_rd_mux = sw_freg_sel ? freg_q[sw_addr[FADDR_W-1:0]] :
                     (sw_addr == SW_ACC_OFS) ? acc_q :
                     (sw_addr == SW_STAT_OFS) ? {6'h00, skip_q, zero_q} : 8'h00;
  // What the accumulator holds next when no instruction writes it.
  logic [7:0] acc_keep;
  logic sw_same_freg;
  assign acc_keep = sw_acc_wr ? sw_wdata : acc_q;
  assign sw_same_freg = sw_wr & sw_freg_sel & (sw_addr[FADDR_W-1:0] == faddr);

  // ==========================================================
  // State
  // ==========================================================
  generate
    for (genvar i = 0; i < 2**FADDR_W; i++) begin : g_freg
      logic core_hit;
      logic sw_hit;
      assign core_hit = wr_freg & (faddr == FADDR_W'(i));
      assign sw_hit = sw_wr & sw_freg_sel & (sw_addr[FADDR_W-1:0] == FADDR_W'(i));
      // The core write wins a collision with software.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          freg_q[i] <= FREG_RST;
        end else if (core_hit) begin
          freg_q[i] <= alu_bus.result;
        end else if (sw_hit) begin
          freg_q[i] <= sw_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= ACC_RST;
    end else if (wr_acc) begin
      acc_q <= alu_bus.result;
    end else if (sw_acc_wr) begin
      acc_q <= sw_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      zero_q <= 1'b0;
    end else if (upd_zero) begin
      zero_q <= alu_bus.zero;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      skip_q <= 1'b0;
    end else if (take) begin
      skip_q <= exec_en & is_skip_op & alu_bus.zero;
    end
  end

  logic skip_pulse_q;
  logic [7:0] sw_rdata_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      skip_pulse_q <= 1'b0;
      sw_rdata_q <= 8'h00;
    end else begin
      skip_pulse_q <= take & skip_q;
      sw_rdata_q <= sw_rd ? sw_rd_mux : 8'h00;
    end
  end

  assign skip_pulse = skip_pulse_q;
  assign acc_out = acc_q;
  assign zero_flag = zero_q;
  assign sw_rdata = sw_rdata_q;

  // ==========================================================
  // Checking helpers
  // ==========================================================
  // Clocks since the last enable, counted apart from the divider so that the
  // spacing check does not merely restate the divider's own compare.
  localparam logic [7:0] GAP_EXP = 8'(CYC_LEN - 1);
  logic [7:0] gap_q;
  logic gap_seen_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 8'h00;
      gap_seen_q <= 1'b0;
    end else if (instr_ready) begin
      gap_q <= 8'h00;
      gap_seen_q <= 1'b1;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Checks that the accumulator holds compare against acc_keep, so a software write that lands
  // beside a core instruction is not taken for a fault.
  AST_DEC_VALUE: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_DEC_SKIP && !dest_freg |=> acc_q == $past(freg_q[faddr]) - 8'h01)
    else $error("Decrement result wrong in accumulator.");
  AST_DEST_FREG: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && has_dest && dest_freg |=> acc_q == $past(acc_keep))
    else $error("Accumulator changed for file destination.");
  AST_DEC_SKIP: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_DEC_SKIP && freg_q[faddr] == 8'h01 |=> skip_q)
    else $error("Zero decrement did not arm skip.");
  AST_INC_NOFLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_INC_SKIP |=> $stable(zero_q))
    else $error("Increment altered zero flag.");
  AST_SKIP_SQUASH: assert property (@(posedge clk_sys) disable iff (!rstn)
    take && skip_q |=> skip_pulse && !skip_q && acc_q == $past(acc_keep))
    else $error("Skipped word was not squashed.");
  AST_OR_LIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_OR_LIT |=> acc_q == ($past(acc_q) | $past(instr_word[7:0])))
    else $error("OR literal result wrong.");
  AST_OR_FREG_Z: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_OR_FREG && (acc_q | freg_q[faddr]) == 8'h00 |=> zero_q)
    else $error("OR register did not set zero flag.");
  AST_LOAD_LIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_LOAD_LIT |=> acc_q == $past(instr_word[7:0]) && $stable(zero_q))
    else $error("Load literal wrong.");
  AST_STORE: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op == FRA_OP_STORE_ACC |=> freg_q[$past(faddr)] == $past(acc_q))
    else $error("Store accumulator wrong.");
  AST_ZERO_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    upd_zero && !alu_bus.zero |=> !zero_q)
    else $error("Zero flag not cleared.");
  AST_CYC_SPACING: assert property (@(posedge clk_sys) disable iff (!rstn)
    instr_ready && gap_seen_q |-> gap_q == GAP_EXP)
    else $error("Instruction cycle enable spacing wrong.");
  AST_DEC_FREG: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_dec && dest_freg |=> freg_q[$past(faddr)] == $past(freg_q[faddr]) - 8'h01)
    else $error("Decrement result wrong in file register.");
  AST_DEC_NOFLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_dec |=> $stable(zero_q))
    else $error("Decrement altered zero flag.");
  AST_DEST_ACC: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && has_dest && !dest_freg && !sw_same_freg |=> freg_q[$past(faddr)] == $past(freg_q[faddr]))
    else $error("File register changed for accumulator destination.");
  AST_DEC_NOSKIP: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_dec && freg_q[faddr] != 8'h01 |=> !skip_q)
    else $error("Nonzero decrement armed skip.");
  AST_INC_VALUE: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_inc && !dest_freg |=> acc_q == $past(freg_q[faddr]) + 8'h01)
    else $error("Increment result wrong in accumulator.");
  AST_INC_FREG: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_inc && dest_freg |=> freg_q[$past(faddr)] == $past(freg_q[faddr]) + 8'h01)
    else $error("Increment result wrong in file register.");
  AST_INC_SKIP: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_inc && freg_q[faddr] == 8'hFF |=> skip_q)
    else $error("Zero increment did not arm skip.");
  AST_SQUASH_QUIET: assert property (@(posedge clk_sys) disable iff (!rstn)
    take && skip_q && !sw_same_freg |=> $stable(zero_q) && freg_q[$past(faddr)] == $past(freg_q[faddr]))
    else $error("Squashed word changed state.");
  AST_OR_LIT_Z: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_orl && (acc_q | instr_word[7:0]) == 8'h00 |=> zero_q)
    else $error("OR literal did not set zero flag.");
  AST_OR_FREG_VAL: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_orf && dest_freg |=> freg_q[$past(faddr)] == ($past(acc_q) | $past(freg_q[faddr])))
    else $error("OR register result wrong in file register.");
  AST_STORE_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_sto |=> $stable(zero_q) && acc_q == $past(acc_keep))
    else $error("Store accumulator altered accumulator or flag.");
  AST_ORF_NONZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_orf && (acc_q | freg_q[faddr]) != 8'h00 |=> !zero_q)
    else $error("OR register left zero flag set.");
  AST_ORL_NONZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    exec_en && op_orl && (acc_q | instr_word[7:0]) != 8'h00 |=> !zero_q)
    else $error("OR literal left zero flag set.");
  COV_SKIP: cover property (@(posedge clk_sys) disable iff (!rstn) take && skip_q);
  COV_OR_ZERO: cover property (@(posedge clk_sys) disable iff (!rstn) upd_zero && alu_bus.zero);
  COV_STORE: cover property (@(posedge clk_sys) disable iff (!rstn) exec_en && op == FRA_OP_STORE_ACC);
  COV_INC_SKIP: cover property (@(posedge clk_sys) disable iff (!rstn) exec_en && op_inc && freg_q[faddr] == 8'hFF);
  COV_DEC_NOSKIP: cover property (@(posedge clk_sys) disable iff (!rstn) exec_en && op_dec && freg_q[faddr] != 8'h01);
endmodule : fra_exec

// file: verilog/fra_pkg.sv
// Purpose: Shared constants and types for the file register ALU block.
// Assumes: 14-bit instruction words, 8-bit data, 128 file registers.
// Notes: Operation summary below.
package fra_pkg;
  // ==========================================================
  // Widths and timing
  // ==========================================================
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int SW_ADDR_W = 8;
  localparam int CYC_CLKS = 4;
  // ==========================================================
  // Instruction encodings, upper bits of the word
  // ==========================================================
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_OR_FREG = 6'h04;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
  localparam logic [6:0] OPC_STORE_ACC = 7'h01;
  localparam int DEST_BIT = 7;
  // ==========================================================
  // Software port map
  // ==========================================================
  localparam logic [7:0] SW_ACC_OFS = 8'h80;
  localparam logic [7:0] SW_STAT_OFS = 8'h81;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FREG_RST = 8'h00;
  typedef enum logic [2:0] {
    FRA_OP_NONE = 3'h0,
    FRA_OP_DEC_SKIP = 3'h1,
    FRA_OP_INC_SKIP = 3'h2,
    FRA_OP_OR_LIT = 3'h3,
    FRA_OP_OR_FREG = 3'h4,
    FRA_OP_LOAD_LIT = 3'h5,
    FRA_OP_STORE_ACC = 3'h6
  } fra_op_t;
endpackage : fra_pkg
